// >>> tb/smc_adc_model.sv
// Converter model: answers each start with one done pulse.
// Assumes one start at a time; data is base plus selector.
module smc_adc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Converter pins
   input wire logic adc_start,
   input wire logic [5:0] adc_sel,
   output logic adc_done,
   output logic [13:0] adc_data,
   // Control
   input wire logic slow,
   input wire logic [13:0] data_base
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_r;
   logic [5:0] sel_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wait_r <= 0;
         sel_r <= 6'h00;
         adc_done <= 1'b0;
         adc_data <= 14'h0000;
      end else begin
         adc_done <= 1'b0;
         // Data is only valid with done
         adc_data <= ~adc_data;
         if (adc_start) begin
            wait_r <= slow ? 6 : 1;
            sel_r <= adc_sel;
         end else if (wait_r == 1) begin
            wait_r <= 0;
            adc_done <= 1'b1;
            adc_data <= data_base + 14'(sel_r);
         end else if (wait_r != 0) begin
            wait_r <= wait_r - 1;
         end
      end
   end
endmodule

// >>> tb/smc_ctrl_asserts.sv
// Concurrent checks on the scan, measure and sleep controller.
// Assumes DWELL_CYC of 8 and the top module's ports only.
module smc_ctrl_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Inputs
   input wire logic cmd_valid,
   input wire smc_pkg::smc_cmd_type cmd_code,
   input wire logic cmd_addr_all,
   input wire logic [5:0] cmd_suffix,
   input wire logic is_top,
   input wire logic [3:0] temp_threshold_check_enables,
   input wire logic [5:0] reg_addr,
   // Outputs
   input wire logic [13:0] reg_rdata,
   input wire logic resp_ack,
   input wire logic resp_nak,
   input wire logic adc_start,
   input wire logic [5:0] adc_sel,
   input wire logic thermistor_bias_output,
   input wire logic scan_cont_r,
   input wire logic sleep_r,
   input wire logic busy,
   input wire logic [3:0] temp_fault_r
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   wire cmd_cnt = cmd_valid && !sleep_r && (cmd_code inside {smc_pkg::CMD_SCAN, smc_pkg::CMD_SCAN_TEMP,
      smc_pkg::CMD_SCAN_CONT, smc_pkg::CMD_MEASURE});
   wire sleep_cmd = cmd_valid && cmd_code == smc_pkg::CMD_SLEEP && !sleep_r;
   wire wake_cmd = cmd_valid && cmd_code == smc_pkg::CMD_WAKEUP;
   sequence s_meas;
      cmd_valid && cmd_code == smc_pkg::CMD_MEASURE && !busy && !sleep_r && cmd_suffix <= 6'h0c;
   endsequence
   sequence s_cnt;
      cmd_cnt && reg_addr == 6'h16 ##1 reg_addr == 6'h16;
   endsequence
   a_meas_start: assert property (s_meas |-> ##2 adc_start && adc_sel == $past(cmd_suffix, 2))
      else $error("measure start wrong");
   a_cnt_step: assert property (s_cnt |-> reg_rdata[3:0] == $past(reg_rdata[3:0]) + 4'h1)
      else $error("receipt count step wrong");
   a_bias_dwell: assert property ($rose(thermistor_bias_output) |-> !adc_start [*8] ##[1:4] adc_start)
      else $error("bias dwell wrong");
   a_bias_ext: assert property (adc_start && adc_sel inside {[6'h11:6'h14]} |-> thermistor_bias_output)
      else $error("bias off in conversion");
   a_nak_indiv: assert property (sleep_cmd && !cmd_addr_all |-> resp_nak && !resp_ack)
      else $error("single sleep not refused");
   a_ack_top: assert property (sleep_cmd && cmd_addr_all && is_top |-> resp_ack && !resp_nak)
      else $error("top sleep not acked");
   a_fault_sticky: assert property (($past(temp_fault_r) & ~temp_fault_r) == 4'h0)
      else $error("fault cleared");
   a_fault_en: assert property ((temp_fault_r & ~$past(temp_fault_r)
      & ~$past(temp_threshold_check_enables)) == 4'h0)
      else $error("fault on disabled input");
   a_inhibit_clr: assert property (cmd_valid && cmd_code == smc_pkg::CMD_SCAN_INHIBIT && !sleep_r
      |=> !scan_cont_r)
      else $error("inhibit kept scanning");
   a_wake_clr: assert property (sleep_r && wake_cmd |=> !sleep_r)
      else $error("wakeup ignored");
   a_sleep_hold: assert property (sleep_r && !wake_cmd |=> sleep_r)
      else $error("left sleep without wakeup");
endmodule
bind smc_ctrl smc_ctrl_chk u_chk (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .cmd_addr_all(cmd_addr_all), .cmd_suffix(cmd_suffix), .is_top(is_top), .reg_addr(reg_addr),
   .temp_threshold_check_enables(temp_threshold_check_enables), .reg_rdata(reg_rdata), .resp_ack(resp_ack),
   .resp_nak(resp_nak), .adc_start(adc_start), .adc_sel(adc_sel), .thermistor_bias_output(thermistor_bias_output),
   .scan_cont_r(scan_cont_r), .sleep_r(sleep_r), .busy(busy), .temp_fault_r(temp_fault_r));

// >>> tb/testbench.sv
// Self-checking bench for the scan, measure and sleep controller.
// Assumes the converter model and shortened dwell and sleep waits.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0, cmd_addr_all = 1'b0, is_top = 1'b1;
   logic port1_comm = 1'b0, slow = 1'b0, watchdog_en = 1'b0, watchdog_expired = 1'b0, cont_tick = 1'b0;
   smc_pkg::smc_cmd_type cmd_code = smc_pkg::CMD_NONE;
   smc_pkg::smc_rate_type chain_rate = smc_pkg::RATE_500K;
   logic [5:0] cmd_suffix = 6'h00, reg_addr = 6'h16, adc_sel;
   logic [3:0] tst_en = 4'h0, exp_cnt = 4'h0, temp_fault_r;
   logic [13:0] thr = 14'h0200, base = 14'h0100, reg_rdata, adc_data, meas_result_r;
   logic resp_ack, resp_nak, adc_start, adc_done, bias, scan_cont_r, sleep_r, busy, ack_seen, nak_seen;
   logic [5:0] sels [$];
   logic [5:0] ord [7] = '{6'h11, 6'h12, 6'h13, 6'h14, 6'h10, 6'h16, 6'h17};
   int err_count = 0, compares = 0, cyc = 0, n_start = 0, n, i;
   smc_ctrl #(.DWELL_CYC(8), .WAIT_500K_CYC(20), .WAIT_250K_CYC(30), .WAIT_125K_CYC(40), .WAIT_62K5_CYC(50)) DUT (
      .clk(clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr_all(cmd_addr_all),
      .cmd_suffix(cmd_suffix), .is_top(is_top), .port1_comm(port1_comm), .chain_rate(chain_rate),
      .temp_threshold_check_enables(tst_en), .temp_threshold(thr), .watchdog_en(watchdog_en),
      .watchdog_expired(watchdog_expired), .cont_tick(cont_tick), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
      .resp_ack(resp_ack), .resp_nak(resp_nak), .adc_start(adc_start), .adc_sel(adc_sel), .adc_done(adc_done),
      .adc_data(adc_data), .thermistor_bias_output(bias), .scan_cont_r(scan_cont_r), .sleep_r(sleep_r),
      .busy(busy), .temp_fault_r(temp_fault_r), .meas_result_r(meas_result_r));
   smc_adc_model u_adc (.clk(clk), .rstn(rstn), .adc_start(adc_start), .adc_sel(adc_sel), .adc_done(adc_done),
      .adc_data(adc_data), .slow(slow), .data_base(base));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (adc_start === 1'b1) begin
         n_start <= n_start + 1;
         sels.push_back(adc_sel);
      end
      if (cyc == 30000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic chk(string what, logic [13:0] seen, logic [13:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cmd(smc_pkg::smc_cmd_type code, logic all, logic [5:0] sfx);
      @(negedge clk);
      {cmd_code, cmd_addr_all, cmd_suffix, cmd_valid} = {code, all, sfx, 1'b1};
      #1 {ack_seen, nak_seen} = {resp_ack, resp_nak};
      @(negedge clk);
      cmd_valid = 1'b0;
      if (code inside {smc_pkg::CMD_SCAN, smc_pkg::CMD_SCAN_TEMP, smc_pkg::CMD_SCAN_CONT, smc_pkg::CMD_MEASURE})
         exp_cnt++;
   endtask
   task automatic idle();
      for (int k = 0; k < 400 && busy !== 1'b0; k++) @(negedge clk);
      chk("busy", 14'(busy), 14'h0000);
   endtask
   task automatic nap(int c);
      repeat (c) @(negedge clk);
   endtask
   task automatic sleep_in(int lim);
      for (int k = 0; k < lim && sleep_r !== 1'b1; k++) @(negedge clk);
      chk("sleep", 14'(sleep_r), 14'h0001);
   endtask
   task automatic t_measure();
      chk("idle state", {temp_fault_r, bias, scan_cont_r, sleep_r, busy}, 14'h0000);
      chk("count", reg_rdata, 14'h0000);
      for (logic [5:0] s = 6'h00; s <= 6'h15; s++) begin
         n = n_start;
         cmd(smc_pkg::CMD_MEASURE, 1'b0, s);
         idle();
         chk("starts", 14'(n_start - n), 14'(s <= 6'h0c || s >= 6'h10));
         if (s <= 6'h0c || s >= 6'h10) begin
            chk("sel", 14'(sels[$]), 14'(s));
            chk("result", meas_result_r, base + 14'(s));
         end
      end
      chk("count", reg_rdata, {10'h000, exp_cnt});
      $display("measure test done");
   endtask
   task automatic t_temp();
      {slow, tst_en} = {1'b1, 4'h5};
      sels.delete();
      n = n_start;
      cmd(smc_pkg::CMD_SCAN_TEMP, 1'b1, 6'h00);
      cmd(smc_pkg::CMD_MEASURE, 1'b0, 6'h01);
      idle();
      chk("scan starts", 14'(n_start - n), 14'h0007);
      for (i = 0; i < 7; i++) chk("scan sel", 14'(sels[i]), 14'(ord[i]));
      for (i = 0; i < 4; i++) begin
         reg_addr = 6'h11 + 6'(i);
         #1 chk("temp result", reg_rdata, base + 14'h0011 + 14'(i));
      end
      reg_addr = 6'h16;
      #1 chk("count", reg_rdata, {10'h000, exp_cnt});
      chk("faults", {9'h000, bias, temp_fault_r}, 14'h0005);
      slow = 1'b0;
      $display("temperature test done");
   endtask
   task automatic t_sleep();
      cmd(smc_pkg::CMD_SLEEP, 1'b0, 6'h00);
      chk("nak", 14'(nak_seen), 14'h0001);
      nap(60);
      chk("no sleep", 14'(sleep_r), 14'h0000);
      cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
      chk("ack", 14'({ack_seen, nak_seen}), 14'h0002);
      nap(5);
      port1_comm = 1'b1;
      nap(1);
      port1_comm = 1'b0;
      nap(60);
      chk("cancelled", 14'(sleep_r), 14'h0000);
      cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
      nap(15);
      cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
      nap(15);
      chk("restarted", 14'(sleep_r), 14'h0000);
      for (i = 0; i < 4; i++) begin
         if (i != 0) begin
            chain_rate = smc_pkg::smc_rate_type'(i);
            cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
         end
         sleep_in(23 + 10 * i);
         cmd(smc_pkg::CMD_WAKEUP, 1'b1, 6'h00);
         chk("awake", 14'(sleep_r), 14'h0000);
      end
      chain_rate = smc_pkg::RATE_500K;
      $display("sleep test done");
   endtask
   task automatic t_cont();
      cmd(smc_pkg::CMD_SCAN_INHIBIT, 1'b1, 6'h00);
      cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
      sleep_in(23);
      cmd(smc_pkg::CMD_WAKEUP, 1'b1, 6'h00);
      cmd(smc_pkg::CMD_SCAN_CONT, 1'b1, 6'h00);
      idle();
      n = n_start;
      cont_tick = 1'b1;
      nap(1);
      cont_tick = 1'b0;
      idle();
      chk("tick scan", {13'h0000, scan_cont_r}, 14'h0001);
      chk("tick starts", 14'(n_start - n), 14'h0007);
      cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
      sleep_in(23);
      cmd(smc_pkg::CMD_WAKEUP, 1'b1, 6'h00);
      cmd(smc_pkg::CMD_SCAN_INHIBIT, 1'b1, 6'h00);
      n = n_start;
      cont_tick = 1'b1;
      nap(1);
      cont_tick = 1'b0;
      nap(20);
      chk("stopped", {13'h0000, scan_cont_r} + 14'(n_start - n), 14'h0000);
      is_top = 1'b0;
      cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
      nap(60);
      chk("sleep blocked", 14'(sleep_r), 14'h0000);
      {is_top, watchdog_en, watchdog_expired} = 3'h7;
      nap(1);
      watchdog_expired = 1'b0;
      nap(3);
      chk("watchdog sleep", 14'(sleep_r), 14'h0001);
      cmd(smc_pkg::CMD_WAKEUP, 1'b1, 6'h00);
      cmd(smc_pkg::CMD_SLEEP, 1'b1, 6'h00);
      sleep_in(23);
      chk("count", reg_rdata, {10'h000, exp_cnt});
      $display("continuous test done");
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      nap(20);
      rstn = 1'b1;
      nap(1);
      t_measure();
      t_temp();
      t_sleep();
      t_cont();
      finish_test();
   end
endmodule

// >>> verilog/smc_conv_if.sv
// Conversion request and result between controller and converter sequencer.
// Assumes one clock shared by both ends.
interface smc_conv_if;
   logic req;
   logic [5:0] sel;
   logic done;
   logic [13:0] data;
   modport ctrl (output req, output sel, input done, input data);
   modport conv (input req, input sel, output done, output data);
endinterface

// >>> verilog/smc_conv_seq.sv
// Hands conversion requests to the external converter, returns its result.
// Assumes the converter answers each start with one done pulse.
module smc_conv_seq (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Controller side
   smc_conv_if.conv cif,
   // Converter pins
   output logic adc_start,
   output logic [5:0] adc_sel,
   input wire logic adc_done,
   input wire logic [13:0] adc_data
);
   logic busy_r;
   logic [13:0] data_r;
   logic done_r;
   wire take = cif.req && !busy_r;
   wire finish = busy_r && adc_done;
   assign cif.done = done_r;
   assign cif.data = data_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy_r <= 1'b0;
         done_r <= 1'b0;
         data_r <= 14'h0000;
         adc_sel <= 6'h00;
         adc_start <= 1'b0;
      end else begin
         done_r <= finish;
         // Start leaves together with its selector, never ahead of it
         adc_start <= take;
         if (take) begin
            busy_r <= 1'b1;
            adc_sel <= cif.sel;
         end else if (finish) begin
            busy_r <= 1'b0;
            data_r <= adc_data;
         end
      end
   end
endmodule

// >>> verilog/smc_ctrl.sv
// Scan, measure and sleep command controller of a cell monitor.
// Assumes commands arrive as one-cycle pulses already decoded and addressed.
// Function
// RULE_01: Scan inhibit clears continuous-scan flag and stops repeating scans.
// RULE_02: Host sends wakeup before scan inhibit when in continuous-scan plus sleep.
// RULE_03: After inhibit of continuous scan, plain sleep is blocked until reset or watchdog.
// RULE_04: Addressed measure bumps receipt counter then starts one measurement.
// RULE_05: Measure carries a six-bit element selector.
// RULE_06: Selector 0 is stack voltage, 1 to 12 are cell voltages.
// RULE_07: 0x10 internal temp, 0x11-0x14 external temps, 0x15 raw reference.
// RULE_08: Do one conversion, store result, return to standby.
// RULE_09: Four-bit wrapping receipt counter at 0x16 counts scan and measure commands.
// RULE_10: Requests while busy are dropped but still counted.
// RULE_11: Each temperature input yields a 14-bit result in its own register.
// RULE_12: Temperature work: bias on, 2.5 ms dwell, convert inputs, bias off.
// RULE_13: Temperature scan also samples internal temp, aux reference, loopback.
// RULE_14: Enabled inputs fault when below threshold; enables reset to zero.
// RULE_15: In sleep only comms, slow oscillator and registers stay active; the code still starts continuous scans on cont_tick.
// RULE_16: Individually addressed sleep is rejected with NAK.
// RULE_17: Top device answers ACK to a valid sleep command.
// RULE_18: Sleep waits on a timer; port 1 traffic cancels, new sleep restarts.
// RULE_19: Sleep wait at most 500/1000/2000/4000 us by chain rate.
// RULE_20: No comms-fault timeout is applied to the sleep command.
// RULE_21: Expired enabled watchdog puts device to sleep.
// RULE_22: Sleep is left only on a valid wakeup command.
// RULE_23: Scan inhibit with no continuous scan changes nothing.
module smc_ctrl #(
   parameter int DWELL_CYC = smc_pkg::BIAS_DWELL_CYC,
   parameter int WAIT_500K_CYC = smc_pkg::SLEEP_WAIT_500K_CYC,
   parameter int WAIT_250K_CYC = smc_pkg::SLEEP_WAIT_250K_CYC,
   parameter int WAIT_125K_CYC = smc_pkg::SLEEP_WAIT_125K_CYC,
   parameter int WAIT_62K5_CYC = smc_pkg::SLEEP_WAIT_62K5_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Decoded command
   input wire logic cmd_valid,
   input wire smc_pkg::smc_cmd_type cmd_code,
   input wire logic cmd_addr_all,
   input wire logic [5:0] cmd_suffix,
   input wire logic is_top,
   input wire logic port1_comm,
   // Configuration and events
   input wire smc_pkg::smc_rate_type chain_rate,
   input wire logic [3:0] temp_threshold_check_enables,
   input wire logic [13:0] temp_threshold,
   input wire logic watchdog_en,
   input wire logic watchdog_expired,
   input wire logic cont_tick,
   // Register read port
   input wire logic [5:0] reg_addr,
   output logic [13:0] reg_rdata,
   // Response
   output logic resp_ack,
   output logic resp_nak,
   // Converter pins
   output logic adc_start,
   output logic [5:0] adc_sel,
   input wire logic adc_done,
   input wire logic [13:0] adc_data,
   // Status
   output logic thermistor_bias_output,
   output logic scan_cont_r,
   output logic sleep_r,
   output logic busy,
   output logic [3:0] temp_fault_r,
   output logic [13:0] meas_result_r
);
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_DWELL = 4'b0010,
      ST_CONV = 4'b0100,
      ST_WAIT = 4'b1000
   } smc_state_type;

   smc_conv_if cif ();
   smc_conv_seq u_seq (
      .clk(clk),
      .rstn(rstn),
      .cif(cif),
      .adc_start(adc_start),
      .adc_sel(adc_sel),
      .adc_done(adc_done),
      .adc_data(adc_data)
   );

   smc_state_type state_r;
   logic [3:0] receipt_cnt_r;
   logic [5:0] sel_r;
   logic multi_r;
   logic sleep_block_r;
   logic sleep_pend_r;
   logic [31:0] sleep_cnt_r;
   logic [31:0] dwell_cnt_r;
   logic [13:0] temp_res_r [4];
   logic bias_r;

   // Command decode
   wire is_cmd = cmd_valid && !sleep_r;
   wire c_scan = is_cmd && (cmd_code == smc_pkg::CMD_SCAN);
   wire c_temp = is_cmd && (cmd_code == smc_pkg::CMD_SCAN_TEMP);
   wire c_cont = is_cmd && (cmd_code == smc_pkg::CMD_SCAN_CONT);
   wire c_inh = is_cmd && (cmd_code == smc_pkg::CMD_SCAN_INHIBIT);
   wire c_meas = is_cmd && (cmd_code == smc_pkg::CMD_MEASURE);
   wire c_sleep = is_cmd && (cmd_code == smc_pkg::CMD_SLEEP);
   wire c_wake = cmd_valid && (cmd_code == smc_pkg::CMD_WAKEUP);
   wire counted = c_scan || c_temp || c_cont || c_meas;
   wire idle = (state_r == ST_IDLE);
   wire cont_start = scan_cont_r && cont_tick && idle;
   wire start = (counted && idle) || cont_start;
   wire start_temp = c_temp || cont_start || (c_meas && cmd_suffix >= smc_pkg::SEL_TEMP_EXT_FIRST
      && cmd_suffix <= smc_pkg::SEL_TEMP_EXT_LAST);
   wire sel_valid = (cmd_suffix <= smc_pkg::SEL_CELL_LAST)
      || (cmd_suffix >= smc_pkg::SEL_TEMP_INT && cmd_suffix <= smc_pkg::SEL_REF_RAW);
   wire [5:0] first_sel = (c_temp || cont_start) ? smc_pkg::SEL_TEMP_EXT_FIRST : cmd_suffix;
   wire scan_last = (sel_r == smc_pkg::SEL_LOOPBACK);
   wire [5:0] scan_next = (sel_r == smc_pkg::SEL_TEMP_EXT_LAST) ? smc_pkg::SEL_TEMP_INT
      : (sel_r == smc_pkg::SEL_TEMP_INT) ? smc_pkg::SEL_AUX_REF : sel_r + 6'h01;
   wire is_ext = (sel_r >= smc_pkg::SEL_TEMP_EXT_FIRST) && (sel_r <= smc_pkg::SEL_TEMP_EXT_LAST);
   wire [1:0] ext_idx = 2'(sel_r - smc_pkg::SEL_TEMP_EXT_FIRST);
   wire sleep_valid = c_sleep && cmd_addr_all && (!sleep_block_r || scan_cont_r); // [RULE_03]
   wire [31:0] wait_cyc = (chain_rate == smc_pkg::RATE_500K) ? 32'(WAIT_500K_CYC)
      : (chain_rate == smc_pkg::RATE_250K) ? 32'(WAIT_250K_CYC)
      : (chain_rate == smc_pkg::RATE_125K) ? 32'(WAIT_125K_CYC) : 32'(WAIT_62K5_CYC);

   assign cif.req = (state_r == ST_CONV);
   assign cif.sel = sel_r;
   assign busy = !idle;
   assign thermistor_bias_output = bias_r;
   // Sleep response; no comms timeout runs on it [RULE_20]
   assign resp_nak = c_sleep && !cmd_addr_all; // [RULE_16]
   assign resp_ack = sleep_valid && is_top; // [RULE_17]
   assign reg_rdata = (reg_addr == smc_pkg::RECEIPT_CNT_OFFSET) ? {10'h000, receipt_cnt_r} // [RULE_09]
      : (reg_addr >= smc_pkg::SEL_TEMP_EXT_FIRST && reg_addr <= smc_pkg::SEL_TEMP_EXT_LAST)
      ? temp_res_r[2'(reg_addr - smc_pkg::SEL_TEMP_EXT_FIRST)] : meas_result_r;

   // Receipt counter, wraps by width; counts even while busy
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         receipt_cnt_r <= smc_pkg::RECEIPT_CNT_RESET;
      else if (counted)
         receipt_cnt_r <= receipt_cnt_r + 4'h1; // [RULE_04] [RULE_10]
   end

   // Continuous-scan flag and sleep block
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scan_cont_r <= 1'b0;
         sleep_block_r <= 1'b0;
      end else begin
         // Watchdog clear first, so a block set in the same cycle wins
         if (watchdog_expired && watchdog_en)
            sleep_block_r <= 1'b0; // [RULE_03]
         if (c_cont)
            scan_cont_r <= 1'b1;
         else if (c_inh && scan_cont_r) begin
            scan_cont_r <= 1'b0; // [RULE_01] [RULE_23]
            sleep_block_r <= 1'b1; // [RULE_03]
         end
      end
   end

   // Sleep entry timer and sleep state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sleep_r <= 1'b0;
         sleep_pend_r <= 1'b0;
         sleep_cnt_r <= 32'h0000_0000;
      end else if (sleep_r) begin
         // Comms, slow oscillator and registers run here; cont_tick still starts continuous scans [RULE_15]
         if (c_wake)
            sleep_r <= 1'b0; // [RULE_22]
      end else if (sleep_valid) begin
         sleep_pend_r <= 1'b1; // [RULE_18]
         sleep_cnt_r <= wait_cyc; // [RULE_19]
      end else if (sleep_pend_r && (port1_comm || cmd_valid)) begin
         sleep_pend_r <= 1'b0; // [RULE_18]
      end else if (watchdog_expired && watchdog_en) begin
         sleep_r <= 1'b1; // [RULE_21]
         sleep_pend_r <= 1'b0;
      end else if (sleep_pend_r) begin
         if (sleep_cnt_r <= 32'h0000_0001) begin
            sleep_r <= 1'b1;
            sleep_pend_r <= 1'b0;
         end else
            sleep_cnt_r <= sleep_cnt_r - 32'h0000_0001;
      end
   end

   // Measurement sequencer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         sel_r <= smc_pkg::SEL_STACK;
         multi_r <= 1'b0;
         bias_r <= 1'b0;
         dwell_cnt_r <= 32'h0000_0000;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               if (start && (sel_valid || c_temp || cont_start)) begin // [RULE_05] [RULE_06] [RULE_07]
                  sel_r <= first_sel;
                  multi_r <= c_temp || cont_start;
                  if (start_temp) begin
                     bias_r <= 1'b1; // [RULE_12]
                     dwell_cnt_r <= 32'(DWELL_CYC);
                     state_r <= ST_DWELL;
                  end else
                     state_r <= ST_CONV;
               end
            end
            ST_DWELL: begin
               if (dwell_cnt_r <= 32'h0000_0001)
                  state_r <= ST_CONV; // [RULE_12]
               else
                  dwell_cnt_r <= dwell_cnt_r - 32'h0000_0001;
            end
            ST_CONV: state_r <= ST_WAIT;
            ST_WAIT: begin
               if (cif.done) begin
                  if (multi_r && !scan_last) begin
                     sel_r <= scan_next; // [RULE_13]
                     state_r <= ST_CONV;
                  end else begin
                     bias_r <= 1'b0; // [RULE_12]
                     state_r <= ST_IDLE; // [RULE_08]
                  end
               end
            end
         endcase
      end
   end

   // Result storage and threshold check
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meas_result_r <= 14'h0000;
         temp_fault_r <= smc_pkg::TST_RESET;
         for (int i = 0; i < 4; i++)
            temp_res_r[i] <= 14'h0000;
      end else if (state_r == ST_WAIT && cif.done) begin
         meas_result_r <= cif.data; // [RULE_08]
         if (is_ext) begin
            temp_res_r[ext_idx] <= cif.data; // [RULE_11]
            if (temp_threshold_check_enables[ext_idx] && cif.data < temp_threshold)
               temp_fault_r[ext_idx] <= 1'b1; // [RULE_14]
         end
      end
   end
endmodule

// >>> verilog/smc_pkg.sv
// Package for the scan, measure and sleep command controller.
// Assumes a 200 MHz core clock; times are given in their own units.
package smc_pkg;
   localparam int CLK_MHZ = 200;
   localparam logic [5:0] RECEIPT_CNT_OFFSET = 6'h16;
   localparam logic [3:0] RECEIPT_CNT_RESET = 4'h0;
   localparam logic [5:0] SEL_STACK = 6'h00;
   localparam logic [5:0] SEL_CELL_FIRST = 6'h01;
   localparam logic [5:0] SEL_CELL_LAST = 6'h0c;
   localparam logic [5:0] SEL_TEMP_INT = 6'h10;
   localparam logic [5:0] SEL_TEMP_EXT_FIRST = 6'h11;
   localparam logic [5:0] SEL_TEMP_EXT_LAST = 6'h14;
   localparam logic [5:0] SEL_REF_RAW = 6'h15;
   // Temperature scan extras: internal temp, aux reference, loopback
   localparam logic [5:0] SEL_AUX_REF = 6'h16;
   localparam logic [5:0] SEL_LOOPBACK = 6'h17;
   localparam int TEMP_BITS = 14;
   localparam logic [3:0] TST_RESET = 4'h0;
   // Bias dwell, least time 2.5 ms, rounds up
   localparam int BIAS_DWELL_NS = 2500000;
   localparam int BIAS_DWELL_CYC = (BIAS_DWELL_NS * CLK_MHZ + 999) / 1000;
   // Longest sleep-entry waits per chain rate, round down
   localparam int SLEEP_WAIT_500K_US = 500;
   localparam int SLEEP_WAIT_250K_US = 1000;
   localparam int SLEEP_WAIT_125K_US = 2000;
   localparam int SLEEP_WAIT_62K5_US = 4000;
   localparam int SLEEP_WAIT_500K_CYC = SLEEP_WAIT_500K_US * CLK_MHZ;
   localparam int SLEEP_WAIT_250K_CYC = SLEEP_WAIT_250K_US * CLK_MHZ;
   localparam int SLEEP_WAIT_125K_CYC = SLEEP_WAIT_125K_US * CLK_MHZ;
   localparam int SLEEP_WAIT_62K5_CYC = SLEEP_WAIT_62K5_US * CLK_MHZ;
   typedef enum logic [1:0] {
      RATE_500K = 2'h0,
      RATE_250K = 2'h1,
      RATE_125K = 2'h2,
      RATE_62K5 = 2'h3
   } smc_rate_type;
   typedef enum logic [2:0] {
      CMD_NONE = 3'h0,
      CMD_SCAN = 3'h1,
      CMD_SCAN_TEMP = 3'h2,
      CMD_SCAN_CONT = 3'h3,
      CMD_SCAN_INHIBIT = 3'h4,
      CMD_MEASURE = 3'h5,
      CMD_SLEEP = 3'h6,
      CMD_WAKEUP = 3'h7
   } smc_cmd_type;
endpackage
